// File: srfd_defines.svh
`ifndef SRFD_DEFINES_SVH
`define SRFD_DEFINES_SVH

// Register map, byte addresses
`define SRFD_ADR_CTRL     4'h0
`define SRFD_ADR_STAT     4'h4

// Control field positions and reset value
`define SRFD_CTRL_INSEL   0
`define SRFD_CTRL_RF      1
`define SRFD_CTRL_STN     2
`define SRFD_CTRL_UNENC   3
`define SRFD_CTRL_RST     4'h5

// Bit counter
`define SRFD_BIT_LAST     4'h9
`define SRFD_BIT_HALF     4'h5
`define SRFD_RUN_MIN      4'h4

// Framing
`define SRFD_COMMA_NEG    10'h0fa
`define SRFD_COMMA_POS    10'h305
`define SRFD_DBL_BYTES    12'h800
`define SRFD_DBL_WIN      3'h5
`define SRFD_AGE_MAX      3'h7

// Decoder
`define SRFD_K28_NEG      6'h0f
`define SRFD_K28_POS      6'h30
`define SRFD_VIOL_CODE    8'he0
`define SRFD_D00          8'h00

// Self-test
`define SRFD_SEED         9'h001

`endif

// File: srfd_pkg.sv
package srfd_pkg;

   typedef enum logic [0:0] {
      FR_SINGLE = 1'b0,
      FR_DOUBLE = 1'b1
   } srfd_frm_t;

   typedef enum logic [1:0] {
      BS_OFF  = 2'b00,
      BS_WAIT = 2'b01,
      BS_RUN  = 2'b10
   } srfd_bist_t;

   typedef struct packed {
      logic [7:0] data;
      logic       special;
      logic       viol;
   } srfd_out_t;

   typedef struct packed {
      logic [3:0]  in1;
      logic [3:0]  in2;
      logic        tied1;
      logic        tied2;
      logic        last_bit;
      logic [9:0]  sr;
      logic [3:0]  bitcnt;
      logic [9:0]  dec;
      logic [9:0]  dec2;
      logic        recovered_byte_clock;
      logic [3:0]  run;
      logic        rf;
      logic        rdy_hold;
      srfd_frm_t   frm;
      logic [11:0] rf_bytes;
      logic        pend;
      logic [3:0]  pend_pos;
      logic [2:0]  pend_age;
      logic        rd;
      srfd_out_t   out;
      logic        rdy_n;
      srfd_bist_t  bist;
      logic        status;
      logic [3:0]  ctrl;
      logic        ack;
      logic [31:0] dat;
   } srfd_state_t;

endpackage : srfd_pkg

// File: srfd_receiver.sv
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "srfd_defines.svh"

// Operation
// - Input select high picks first serial pair, low picks second pair.
// - Status output tied high makes second pair differential, else positive pin single-ended.
// - In translator use, negative second pin level is copied to status output.
// - Bit counter moves shifter into decode register each byte and forms byte clock.
// - Reframing never shortens byte clock period or pulse widths; stretching allowed.
// - Comma K28.5 in stream resets bit counter, aligning bytes to comma.
// - Reframe enable low keeps current alignment, no reframing at all.
// - After reframe enable rises, ready stays inactive until a comma is seen.
// - After 2048 bytes of reframe enable, need two aligned commas within 5 bytes.
// - Shifter takes one bit per bit clock and shows contents to framer each bit.
// - Decoder restores bytes, flag low for data, high for special characters.
// - Bad codes and disparity errors raise violation flag with violation code.
// - Output register updates byte and flags only on byte clock rising edge.
// - Self-test turns output register into LFSR with 511-byte sequence.
// - Synchronized self-test compares each decoded byte with output register contents.
// - Self-test LFSR starts on first received D0.0 loop start character.
// - Once started, each mismatching byte raises violation flag.
// - Expected code violations within the sequence are not reported.
// - Ready pulses high once per completed self-test loop.
// - Leaving and re-entering self-test reinitializes the checker.
// - Self-test enable low enters self-test, which waits for D0.0 first.
// - Reframe enable is sampled on byte clock falling edge.
// - Encoded ready pulses low per byte, only last of comma runs.
// - Unencoded ready signals only when a comma is at the outputs.
module srfd_receiver #(
   parameter logic [11:0] DBL_BYTES = `SRFD_DBL_BYTES,
   parameter logic [2:0]  DBL_WIN   = `SRFD_DBL_WIN
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        serial_in_first_pair_p_i,
   input  wire logic        serial_in_first_pair_n_i,
   input  wire logic        serial_in_second_pair_p_i,
   input  wire logic        serial_in_second_pair_n_i,
   input  wire logic        status_out_tied_i,
   output logic             status_out_o,
   output logic             recovered_byte_clock_o,
   output logic [7:0]       received_byte_o,
   output logic             special_char_flag_o,
   output logic             violation_flag_o,
   output logic             ready_strobe_n_o,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   import srfd_pkg::*;

   srfd_state_t q;
   srfd_state_t s;

   // Returns {valid, 5b value}
   function automatic logic [5:0] dec6(input logic [5:0] c);
      logic [5:0] r;
      r = 6'h00;
      case (c)
         6'h27, 6'h18: r = {1'b1, 5'h00};
         6'h1d, 6'h22: r = {1'b1, 5'h01};
         6'h2d, 6'h12: r = {1'b1, 5'h02};
         6'h31:        r = {1'b1, 5'h03};
         6'h35, 6'h0a: r = {1'b1, 5'h04};
         6'h29:        r = {1'b1, 5'h05};
         6'h19:        r = {1'b1, 5'h06};
         6'h38, 6'h07: r = {1'b1, 5'h07};
         6'h39, 6'h06: r = {1'b1, 5'h08};
         6'h25:        r = {1'b1, 5'h09};
         6'h15:        r = {1'b1, 5'h0a};
         6'h34:        r = {1'b1, 5'h0b};
         6'h0d:        r = {1'b1, 5'h0c};
         6'h2c:        r = {1'b1, 5'h0d};
         6'h1c:        r = {1'b1, 5'h0e};
         6'h17, 6'h28: r = {1'b1, 5'h0f};
         6'h1b, 6'h24: r = {1'b1, 5'h10};
         6'h23:        r = {1'b1, 5'h11};
         6'h13:        r = {1'b1, 5'h12};
         6'h32:        r = {1'b1, 5'h13};
         6'h0b:        r = {1'b1, 5'h14};
         6'h2a:        r = {1'b1, 5'h15};
         6'h1a:        r = {1'b1, 5'h16};
         6'h3a, 6'h05: r = {1'b1, 5'h17};
         6'h33, 6'h0c: r = {1'b1, 5'h18};
         6'h26:        r = {1'b1, 5'h19};
         6'h16:        r = {1'b1, 5'h1a};
         6'h36, 6'h09: r = {1'b1, 5'h1b};
         6'h0e:        r = {1'b1, 5'h1c};
         6'h2e, 6'h11: r = {1'b1, 5'h1d};
         6'h1e, 6'h21: r = {1'b1, 5'h1e};
         6'h2b, 6'h14: r = {1'b1, 5'h1f};
         6'h0f, 6'h30: r = {1'b1, 5'h1c};
         default:      r = 6'h00;
      endcase
      return r;
   endfunction : dec6

   // Returns {valid, 3b value}
   function automatic logic [3:0] dec4(input logic [3:0] c);
      logic [3:0] r;
      r = 4'h0;
      case (c)
         4'hb, 4'h4:             r = {1'b1, 3'h0};
         4'h9:                   r = {1'b1, 3'h1};
         4'h5:                   r = {1'b1, 3'h2};
         4'hc, 4'h3:             r = {1'b1, 3'h3};
         4'hd, 4'h2:             r = {1'b1, 3'h4};
         4'ha:                   r = {1'b1, 3'h5};
         4'h6:                   r = {1'b1, 3'h6};
         4'he, 4'h1, 4'h7, 4'h8: r = {1'b1, 3'h7};
         default:                r = 4'h0;
      endcase
      return r;
   endfunction : dec4

   logic       bit_sel;
   logic       diff_b;
   logic [9:0] sr_n;
   logic       comma;
   logic       hit;
   logic       reframe;
   logic       byte_done;
   logic       want;
   logic       ckr_rise;
   logic       ckr_fall;
   logic [5:0] six;
   logic [3:0] four;
   logic [3:0] four_k;
   logic [5:0] r6;
   logic [3:0] r4;
   logic [2:0] p6;
   logic [2:0] p4;
   logic       k28;
   logic       alt7;
   logic       rd1;
   logic       derr;
   logic       special;
   logic [7:0] byte_v;
   logic       cerr;
   logic [8:0] exp_v;
   logic [8:0] nxt_v;
   logic       mism;
   logic       cur_comma;
   logic       nxt_comma;
   logic       wb_req;

   always_comb begin
      s = q;
      bit_sel = 1'b0;
      diff_b = 1'b0;
      sr_n = 10'h000;
      comma = 1'b0;
      hit = 1'b0;
      reframe = 1'b0;
      byte_done = 1'b0;
      want = 1'b0;
      ckr_rise = 1'b0;
      ckr_fall = 1'b0;
      six = q.dec2[9:4];
      four = q.dec2[3:0];
      four_k = 4'h0;
      r6 = 6'h00;
      r4 = 4'h0;
      p6 = 3'h0;
      p4 = 3'h0;
      k28 = 1'b0;
      alt7 = 1'b0;
      rd1 = 1'b0;
      derr = 1'b0;
      special = 1'b0;
      byte_v = 8'h00;
      cerr = 1'b0;
      exp_v = 9'h000;
      nxt_v = 9'h000;
      mism = 1'b0;
      cur_comma = 1'b0;
      nxt_comma = 1'b0;
      wb_req = wb_cyc_i & wb_stb_i;

      // Pins pass two flops before use
      s.in1 = {serial_in_first_pair_p_i, serial_in_first_pair_n_i,
               serial_in_second_pair_p_i, serial_in_second_pair_n_i};
      s.in2 = q.in1;
      s.tied1 = status_out_tied_i;
      s.tied2 = q.tied1;

      // Equal legs of a pair carry no bit; hold the last one
      if (q.ctrl[`SRFD_CTRL_INSEL]) begin
         bit_sel = (q.in2[3] ^ q.in2[2]) ? q.in2[3] : q.last_bit;
      end else begin
         diff_b = (q.in2[1] ^ q.in2[0]) ? q.in2[1] : q.last_bit;
         bit_sel = q.tied2 ? diff_b : q.in2[1];
      end
      s.last_bit = bit_sel;
      s.status = ~q.tied2 & q.in2[0];

      // One bit per clock; clk_i stands in for the recovered bit clock
      sr_n = {q.sr[8:0], bit_sel};
      s.sr = sr_n;
      comma = (sr_n == `SRFD_COMMA_NEG) | (sr_n == `SRFD_COMMA_POS);
      hit = q.rf & comma & (q.bitcnt != `SRFD_BIT_LAST);
      if (q.frm == FR_DOUBLE) begin
         reframe = hit & q.pend & (q.pend_pos == q.bitcnt) & (q.pend_age <= DBL_WIN);
      end else begin
         reframe = hit;
      end
      if (hit & ~reframe) begin
         s.pend = 1'b1;
         s.pend_pos = q.bitcnt;
         s.pend_age = 3'h0;
      end
      if (reframe) begin
         s.pend = 1'b0;
      end

      byte_done = (q.bitcnt == `SRFD_BIT_LAST) | reframe;
      s.bitcnt = byte_done ? 4'h0 : q.bitcnt + 4'h1;
      if (byte_done) begin
         s.dec2 = q.dec;
         s.dec = sr_n;
         if (!reframe && hit == 1'b0 && q.pend_age != `SRFD_AGE_MAX) begin
            s.pend_age = q.pend_age + 3'h1;
         end
         if (q.rf) begin
            if (q.rf_bytes == DBL_BYTES) begin
               s.frm = FR_DOUBLE;
            end else begin
               s.rf_bytes = q.rf_bytes + 12'h001;
            end
         end
      end
      if (!q.rf) begin
         s.rf_bytes = 12'h000;
         s.frm = FR_SINGLE;
         s.pend = 1'b0;
      end

      // Level changes only after a full half period, so reframe only stretches
      want = s.bitcnt < `SRFD_BIT_HALF;
      if (want != q.recovered_byte_clock && q.run >= `SRFD_RUN_MIN) begin
         s.recovered_byte_clock = want;
         s.run = 4'h0;
      end else if (q.run != 4'hf) begin
         s.run = q.run + 4'h1;
      end
      ckr_rise = s.recovered_byte_clock & ~q.recovered_byte_clock;
      ckr_fall = ~s.recovered_byte_clock & q.recovered_byte_clock;

      if (ckr_fall) begin
         s.rf = q.ctrl[`SRFD_CTRL_RF];
         if (q.ctrl[`SRFD_CTRL_RF] & ~q.rf) begin
            s.rdy_hold = 1'b1;
         end
      end

      // Decode of the older stage; the newer one gives comma lookahead
      r6 = dec6(six);
      k28 = (six == `SRFD_K28_NEG) | (six == `SRFD_K28_POS);
      four_k = (six == `SRFD_K28_POS) ? ~four : four;
      r4 = dec4(four_k);
      alt7 = (four == 4'h7) | (four == 4'h8);
      p6 = 3'($countones(six));
      p4 = 3'($countones(four));
      derr = ((p6 == 3'h4) & q.rd) | ((p6 == 3'h2) & ~q.rd);
      rd1 = (p6 == 3'h3) ? q.rd : (p6 == 3'h4);
      derr = derr | ((p4 == 3'h3) & rd1) | ((p4 == 3'h1) & ~rd1);
      cerr = ~r6[5] | ~r4[3] | derr | (p6 < 3'h2) | (p6 > 3'h4) | (p4 < 3'h1) | (p4 > 3'h3);
      special = k28 | (alt7 & ((r6[4:0] == 5'h17) | (r6[4:0] == 5'h1b) |
                               (r6[4:0] == 5'h1d) | (r6[4:0] == 5'h1e)));
      byte_v = {r4[2:0], r6[4:0]};
      if (cerr) begin
         byte_v = `SRFD_VIOL_CODE;
         special = 1'b1;
      end
      cur_comma = (q.dec2 == `SRFD_COMMA_NEG) | (q.dec2 == `SRFD_COMMA_POS);
      nxt_comma = (q.dec == `SRFD_COMMA_NEG) | (q.dec == `SRFD_COMMA_POS);
      exp_v = {q.out.special, q.out.data};
      nxt_v = {exp_v[7:0], exp_v[8] ^ exp_v[4]};
      mism = {special, byte_v} != exp_v;

      if (q.ctrl[`SRFD_CTRL_STN]) begin
         s.bist = BS_OFF;
      end else if (q.bist == BS_OFF) begin
         s.bist = BS_WAIT;
      end

      if (ckr_rise) begin
         s.rd = p4 == 3'h2 ? rd1 : (p4 == 3'h3);
         case (q.bist)
            BS_WAIT: begin
               s.out.viol = 1'b0;
               s.rdy_n = 1'b1;
               if (!cerr && !special && byte_v == `SRFD_D00 && !q.ctrl[`SRFD_CTRL_STN]) begin
                  s.bist = BS_RUN;
                  {s.out.special, s.out.data} = `SRFD_SEED;
                  s.rdy_n = 1'b0;
               end
            end
            BS_RUN: begin
               s.out.viol = mism;
               {s.out.special, s.out.data} = nxt_v;
               s.rdy_n = nxt_v == `SRFD_SEED;
            end
            default: begin
               if (q.ctrl[`SRFD_CTRL_UNENC]) begin
                  s.out.special = q.dec2[9];
                  s.out.data = q.dec2[8:1];
                  s.out.viol = q.dec2[0];
                  s.rdy_n = ~cur_comma;
               end else begin
                  s.out.data = byte_v;
                  s.out.special = special;
                  s.out.viol = cerr;
                  s.rdy_n = cur_comma & nxt_comma;
               end
               if (q.rdy_hold) begin
                  s.rdy_n = ~cur_comma;
                  s.rdy_hold = ~cur_comma;
               end
            end
         endcase
      end

      // Wishbone classic, ack one cycle after request
      s.ack = wb_req & ~q.ack;
      s.dat = 32'h0000_0000;
      if (wb_req & ~q.ack) begin
         if (wb_we_i && wb_sel_i[0] && wb_adr_i == `SRFD_ADR_CTRL) begin
            s.ctrl = wb_dat_i[3:0];
         end
         if (!wb_we_i) begin
            case (wb_adr_i)
               `SRFD_ADR_CTRL: s.dat = {28'h000_0000, q.ctrl};
               `SRFD_ADR_STAT: s.dat = {16'h0000, q.out.data, 2'h0, q.out.viol,
                                        q.bist, q.frm, q.rf, q.rdy_hold};
               default:        s.dat = 32'h0000_0000;
            endcase
         end
      end

      if (rst_i) begin
         s = '0;
         s.ctrl = `SRFD_CTRL_RST;
         s.rdy_n = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= s;
   end

   assign status_out_o = q.status;
   assign recovered_byte_clock_o = q.recovered_byte_clock;
   assign received_byte_o = q.out.data;
   assign special_char_flag_o = q.out.special;
   assign violation_flag_o = q.out.viol;
   assign ready_strobe_n_o = q.rdy_n;
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;

endmodule : srfd_receiver

// File: srfd_receiver_props.sv
`timescale 1ns/1ps
module srfd_receiver_props (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        serial_in_second_pair_n_i,
   input  wire logic        status_out_tied_i,
   input  wire logic        status_out_o,
   input  wire logic        recovered_byte_clock_o,
   input  wire logic [7:0]  received_byte_o,
   input  wire logic        special_char_flag_o,
   input  wire logic        violation_flag_o,
   input  wire logic        ready_strobe_n_o,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_o
);
   logic [3:0] ctrl_q;
   // Shadow of the control word, so mode-dependent checks know the mode
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ctrl_q <= 4'h5;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0 && wb_sel_i[0])
         ctrl_q <= wb_dat_i[3:0];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_out_on_rise :
      assert property ($changed({received_byte_o, special_char_flag_o, violation_flag_o})
         |-> $rose(recovered_byte_clock_o)) else $error("outputs moved off byte clock rise");
   chk_high_width :
      assert property ($rose(recovered_byte_clock_o) |-> recovered_byte_clock_o [*5])
      else $error("byte clock high too short");
   chk_low_width :
      assert property ($fell(recovered_byte_clock_o) |-> !recovered_byte_clock_o [*5])
      else $error("byte clock low too short");
   chk_clock_runs :
      assert property ($rose(recovered_byte_clock_o) |-> ##[1:15] $fell(recovered_byte_clock_o))
      else $error("byte clock stuck high");
   chk_ready_edge :
      assert property ($changed(ready_strobe_n_o) |-> $rose(recovered_byte_clock_o))
      else $error("ready moved off byte clock rise");
   chk_viol_code :
      assert property (violation_flag_o && ctrl_q[2] && !ctrl_q[3]
         |-> received_byte_o == 8'he0 && special_char_flag_o) else $error("bad violation code");
   chk_status_copy :
      assert property ((!status_out_tied_i) [*6] |-> status_out_o == $past(serial_in_second_pair_n_i, 3))
      else $error("status level not copied");
   chk_tied_quiet :
      assert property (status_out_tied_i [*6] |-> !status_out_o) else $error("status driven while tied");
endmodule : srfd_receiver_props

bind srfd_receiver srfd_receiver_props chk_u (.clk_i, .rst_i, .serial_in_second_pair_n_i,
   .status_out_tied_i, .status_out_o, .recovered_byte_clock_o, .received_byte_o,
   .special_char_flag_o, .violation_flag_o, .ready_strobe_n_o, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o);

// File: srfd_remote_tx.sv
`timescale 1ns/1ps
module srfd_remote_tx (
   input  wire logic clk_i,
   input  wire logic kind_i,
   input  wire logic slip_i,
   output logic      line_p_o,
   output logic      line_n_o
);
   logic [9:0] sh_q  = 10'h000;
   logic [3:0] cnt_q = 4'h0;
   logic       rd_q  = 1'b0;
   logic [9:0] code;
   // Only commas and D0.0 are sent, so no alias comma can form
   assign code = kind_i ? (rd_q ? 10'h18b : 10'h274) : (rd_q ? 10'h305 : 10'h0fa);
   // Bit clock shared with the receiver, so byte rates match exactly
   always_ff @(posedge clk_i) begin
      if (cnt_q == 4'h9 && !slip_i) begin
         sh_q  <= code;
         cnt_q <= 4'h0;
         rd_q  <= rd_q ^ !kind_i;
      end else if (!slip_i) begin
         sh_q  <= {sh_q[8:0], 1'b0};
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // Slip repeats one bit to move the byte boundary
   assign line_p_o = sh_q[9];
   assign line_n_o = ~sh_q[9];
endmodule : srfd_remote_tx

// File: tb_srfd_receiver.sv
`timescale 1ns/1ps
module tb_srfd_receiver;
   import srfd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req   = 1'b0;
   logic        we    = 1'b0;
   logic [3:0]  adr   = 4'h0;
   logic [31:0] wdat  = 32'h0000_0000;
   logic        p2    = 1'b0;
   logic        n2    = 1'b0;
   logic        tied  = 1'b1;
   logic        kind  = 1'b1;
   logic        slip  = 1'b0;
   logic        p1, n1, st, recovered_byte_clock, spec, viol, rdy_n, wb_ack_o, pr, seen;
   logic [7:0]  rbyte;
   logic [31:0] wb_dat_o, rdat;
   int          n_fail = 0;
   int          check_count = 0;
   int          i;
   srfd_remote_tx tx_u (.clk_i(clk_i), .kind_i(kind), .slip_i(slip), .line_p_o(p1),
      .line_n_o(n1));
   srfd_receiver #(.DBL_BYTES(12'h010), .DBL_WIN(3'h5)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .serial_in_first_pair_p_i(p1), .serial_in_first_pair_n_i(n1),
      .serial_in_second_pair_p_i(p2), .serial_in_second_pair_n_i(n2),
      .status_out_tied_i(tied), .status_out_o(st), .recovered_byte_clock_o(recovered_byte_clock),
      .received_byte_o(rbyte), .special_char_flag_o(spec), .violation_flag_o(viol),
      .ready_strobe_n_o(rdy_n), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      req  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      rdat = wb_dat_o;
      req <= 1'b0;
      if (k >= 20) begin
         n_fail++;
         finish_test();
      end
   endtask : wb
   // Waits for the next byte clock rise, sampling once outputs settle
   task next_byte;
      int k;
      logic pv;
      k = 0;
      #1;
      do begin
         pv = recovered_byte_clock;
         @(posedge clk_i);
         #1;
         k++;
      end while (!(pv === 1'b0 && recovered_byte_clock === 1'b1) && k < 40);
      if (k >= 40) begin
         n_fail++;
         finish_test();
      end
   endtask : next_byte
   task wait_for(input logic [7:0] b);
      for (int k = 0; k < 20; k++) begin
         next_byte();
         if (rbyte === b)
            break;
      end
   endtask : wait_for
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      check(rdat, 32'h0000_0005);
      wb(1'b1, 4'h4, 32'h0000_000f);
      wb(1'b0, 4'h0, 32'h0);
      check(rdat, 32'h0000_0005);
      wb(1'b0, 4'h8, 32'h0);
      check(rdat, 32'h0000_0000);
      check(st, 1'b0);
      @(posedge clk_i);
      tied <= 1'b0;
      n2   <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1;
      check(st, 1'b1);
      @(posedge clk_i);
      n2 <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      check(st, 1'b0);
      wb(1'b1, 4'h0, 32'h0000_0007);
      repeat (40) @(posedge clk_i);
      wb(1'b0, 4'h4, 32'h0);
      check(rdat[0], 1'b1);
      check(rdy_n, 1'b1);
      @(posedge clk_i);
      kind <= 1'b0;
      wait_for(8'hbc);
      check(rbyte, 8'hbc);
      check(spec, 1'b1);
      check(viol, 1'b0);
      repeat (3) next_byte();
      check(rdy_n, 1'b1);
      wb(1'b0, 4'h4, 32'h0);
      check(rdat[0], 1'b0);
      @(posedge clk_i);
      kind <= 1'b1;
      for (i = 0; i < 5; i++) begin
         pr = rdy_n;
         next_byte();
         if (rbyte === 8'h00)
            break;
      end
      check(pr, 1'b0);
      check(rbyte, 8'h00);
      check(spec, 1'b0);
      check(rdy_n, 1'b0);
      // Alignment must survive a moved boundary while reframing is off
      wb(1'b1, 4'h0, 32'h0000_0005);
      repeat (3) next_byte();
      @(posedge clk_i);
      kind <= 1'b0;
      slip <= 1'b1;
      @(posedge clk_i);
      slip <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
         next_byte();
         if (rbyte === 8'hbc)
            seen = 1'b1;
      end
      check(seen, 1'b0);
      wb(1'b1, 4'h0, 32'h0000_0007);
      wait_for(8'hbc);
      check(rbyte, 8'hbc);
      wb(1'b1, 4'h0, 32'h0000_0006);
      for (i = 0; i < 10; i++) begin
         next_byte();
         if (viol === 1'b1)
            break;
      end
      check(viol, 1'b1);
      check(rbyte, 8'he0);
      check(spec, 1'b1);
      // Raw mode on the aligned comma stream
      wb(1'b1, 4'h0, 32'h0000_000f);
      repeat (3) next_byte();
      check(rdy_n, 1'b0);
      check(rbyte === 8'h7d || rbyte === 8'h82, 1'b1);
      // Self-test: loop start on D0.0, then D0.0 again mismatches the sequence
      @(posedge clk_i);
      kind <= 1'b1;
      wb(1'b1, 4'h0, 32'h0000_0003);
      wait_for(8'h01);
      check(rbyte, 8'h01);
      check(rdy_n, 1'b0);
      next_byte();
      check(viol, 1'b1);
      check(rbyte, 8'h02);
      check(rdy_n, 1'b0);
      finish_test();
   end
endmodule : tb_srfd_receiver
